// File: psm_defines.svh
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define PSM_CLK_HZ          25000000
`define PSM_CYC_PER_MS      (`PSM_CLK_HZ / 1000)
`define PSM_CYC_PER_US      (`PSM_CLK_HZ / 1000000)
`define PSM_START_DELAY_MS  10000
`define PSM_RAMP_MS         120
`define PSM_PG_WARN_US      3000
`define PSM_AUX_LEAD_MS     450
`define PSM_BLINK_HALF_MS   250
`define PSM_CNT_W           28

// ----------------------------------------------------------------------------
// Management bus addressing
// ----------------------------------------------------------------------------
`define PSM_DIR_BIT         0
`define PSM_PREFIX_HI       7
`define PSM_PREFIX_LO       5
`define PSM_SLOT_HI         4
`define PSM_SLOT_LO         1
`define PSM_UNIT_PREFIX     3'h4
`define PSM_BCAST_ADDR7     7'h00
`define PSM_ARA_ADDR7       7'h0C

// ----------------------------------------------------------------------------
// Setpoint
// ----------------------------------------------------------------------------
`define PSM_SETPOINT_W      8
`define PSM_NOMINAL_SETPT   8'h36

`endif

// File: psm_pkg.sv
`default_nettype none

package psm_pkg;

  // Output sequencer, Gray coded along the start-up path
  typedef enum logic [2:0] {
    PSM_OFF  = 3'h0,
    PSM_WAIT = 3'h1,
    PSM_RAMP = 3'h3,
    PSM_ON   = 3'h2,
    PSM_WARN = 3'h6
  } psm_seq_state_t;

endpackage

`default_nettype wire

// File: psm_addr_if.sv
`default_nettype none

interface psm_addr_if;
  logic [7:0] addr_byte;
  logic [3:0] slot_bits;
  logic       hit_unit;
  logic       hit_bcast_write;
  logic       hit_bcast_read;
  logic       hit_ara;

  modport requester (output addr_byte, output slot_bits,
                     input hit_unit, input hit_bcast_write,
                     input hit_bcast_read, input hit_ara);
  modport matcher   (input addr_byte, input slot_bits,
                     output hit_unit, output hit_bcast_write,
                     output hit_bcast_read, output hit_ara);
endinterface

`default_nettype wire

// File: psm_addr_match.sv
`include "psm_defines.svh"
`default_nettype none

module psm_addr_match (
  psm_addr_if.matcher bus
);

  function automatic logic addr7_is(input logic [7:0] b, input logic [6:0] a);
    addr7_is = (b[7:1] == a);
  endfunction

  logic dir_read;

  always_comb begin
    dir_read            = bus.addr_byte[`PSM_DIR_BIT];
    bus.hit_unit        = (bus.addr_byte[`PSM_PREFIX_HI:`PSM_PREFIX_LO] == `PSM_UNIT_PREFIX)
                          && (bus.addr_byte[`PSM_SLOT_HI:`PSM_SLOT_LO] == bus.slot_bits);
    bus.hit_bcast_write = addr7_is(bus.addr_byte, `PSM_BCAST_ADDR7) && !dir_read;
    bus.hit_bcast_read  = addr7_is(bus.addr_byte, `PSM_BCAST_ADDR7) && dir_read;
    bus.hit_ara         = addr7_is(bus.addr_byte, `PSM_ARA_ADDR7) && dir_read;
  end

endmodule

`default_nettype wire

// File: psm_top.sv
`include "psm_defines.svh"
`default_nettype none

module psm_top #(
  parameter int DELAY_CYC = `PSM_CYC_PER_MS * `PSM_START_DELAY_MS,
  parameter int RAMP_CYC  = `PSM_CYC_PER_MS * `PSM_RAMP_MS,
  parameter int PG_CYC    = `PSM_CYC_PER_US * `PSM_PG_WARN_US,
  parameter int LEAD_CYC  = `PSM_CYC_PER_MS * `PSM_AUX_LEAD_MS,
  parameter int BLINK_CYC = `PSM_CYC_PER_MS * `PSM_BLINK_HALF_MS
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  // Mode and identification pins
  input  wire logic                       i_mode_pin_open,
  input  wire logic                       i_mode_pin_res_ok,
  input  wire logic [1:0]                 i_unit_select_pin,
  input  wire logic [1:0]                 i_rack_select_pin,
  // Received address byte
  input  wire logic [7:0]                 i_addr_byte,
  input  wire logic                       i_addr_valid,
  // Voltage programming
  input  wire logic                       i_vprog_open_or_high,
  input  wire logic [`PSM_SETPOINT_W-1:0] i_vprog_code,
  input  wire logic                       i_fw_vset_valid,
  input  wire logic [`PSM_SETPOINT_W-1:0] i_fw_vset_code,
  // Input supply sense
  input  wire logic                       i_ac_in_regulation,
  input  wire logic                       i_ac_below_80v,
  // Mode and address answers
  output logic                            o_bus_mode,
  output logic                            o_rs485_mode,
  output logic                            o_addr_ack,
  output logic                            o_addr_read,
  output logic                            o_invalid_cmd,
  // Setpoint
  output logic [`PSM_SETPOINT_W-1:0]      o_setpoint_code,
  output logic                            o_fw_vset_owner,
  // Output sequencing
  output logic                            o_auxiliary_supply_output,
  output logic                            o_main_enable,
  output logic                            o_main_ramping,
  output logic                            o_main_in_regulation,
  output logic                            o_power_good_warning,
  output logic                            o_input_led_blink
);

  if (DELAY_CYC < 1 || RAMP_CYC < 1 || PG_CYC < 1 || LEAD_CYC < 1 || BLINK_CYC < 1 ||
      DELAY_CYC + RAMP_CYC >= (1 << `PSM_CNT_W) || LEAD_CYC + RAMP_CYC >= (1 << `PSM_CNT_W) ||
      PG_CYC >= (1 << `PSM_CNT_W) || BLINK_CYC >= (1 << `PSM_CNT_W) ||
      DELAY_CYC + RAMP_CYC < LEAD_CYC) begin : g_bad_params
    $error("psm_top: timing parameters out of range");
  end

  localparam logic [`PSM_CNT_W-1:0] DELAY_LD = `PSM_CNT_W'(DELAY_CYC - 1);
  localparam logic [`PSM_CNT_W-1:0] RAMP_LD  = `PSM_CNT_W'(RAMP_CYC - 1);
  localparam logic [`PSM_CNT_W-1:0] PG_LD    = `PSM_CNT_W'(PG_CYC - 1);
  localparam logic [`PSM_CNT_W-1:0] LEAD_LD  = `PSM_CNT_W'(LEAD_CYC - 1);
  localparam logic [`PSM_CNT_W-1:0] BLINK_LD = `PSM_CNT_W'(BLINK_CYC - 1);

  // --------------------------------------------------------------------------
  // Mode selection and address matching
  // --------------------------------------------------------------------------
  psm_addr_if addr_if ();

  assign addr_if.addr_byte = i_addr_byte;
  assign addr_if.slot_bits = {i_rack_select_pin, i_unit_select_pin};

  psm_addr_match u_match (
    .bus (addr_if.matcher)
  );

  logic bus_mode_q, bus_mode_d, rs485_q, rs485_d;
  logic ack_q, ack_d, read_q, read_d, inval_q, inval_d;

  always_comb begin
    rs485_d    = !i_mode_pin_open && i_mode_pin_res_ok;
    bus_mode_d = !rs485_d;
    ack_d      = bus_mode_q && i_addr_valid &&
                 (addr_if.hit_unit || addr_if.hit_bcast_write || addr_if.hit_ara);
    inval_d    = bus_mode_q && i_addr_valid && addr_if.hit_bcast_read;
    read_d     = i_addr_valid ? i_addr_byte[`PSM_DIR_BIT] : read_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bus_mode_q <= 1'b1;
      rs485_q    <= 1'b0;
      ack_q      <= 1'b0;
      read_q     <= 1'b0;
      inval_q    <= 1'b0;
    end else begin
      bus_mode_q <= bus_mode_d;
      rs485_q    <= rs485_d;
      ack_q      <= ack_d;
      read_q     <= read_d;
      inval_q    <= inval_d;
    end
  end

  // --------------------------------------------------------------------------
  // Setpoint ownership
  // --------------------------------------------------------------------------
  logic                       owner_q, owner_d;
  logic [`PSM_SETPOINT_W-1:0] setpt_q, setpt_d;

  always_comb begin
    owner_d = owner_q || i_fw_vset_valid;
    if (i_fw_vset_valid) begin
      setpt_d = i_fw_vset_code;
    end else if (owner_q) begin
      setpt_d = setpt_q;
    end else if (i_vprog_open_or_high) begin
      setpt_d = `PSM_NOMINAL_SETPT;
    end else begin
      setpt_d = i_vprog_code;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      owner_q <= 1'b0;
      setpt_q <= `PSM_NOMINAL_SETPT;
    end else begin
      owner_q <= owner_d;
      setpt_q <= setpt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output start-up and hold-up sequencer
  // --------------------------------------------------------------------------
  psm_pkg::psm_seq_state_t  st_q, st_d;
  logic [`PSM_CNT_W-1:0]    cnt_q, cnt_d;
  logic                     aux_q, aux_d, men_q, men_d, ramp_q, ramp_d;
  logic                     reg_q, reg_d, pgw_q, pgw_d;
  logic                     cnt_done;

  always_comb begin
    cnt_done = (cnt_q == '0);
    st_d     = st_q;
    cnt_d    = cnt_done ? cnt_q : cnt_q - `PSM_CNT_W'(1);
    unique case (st_q)
      psm_pkg::PSM_OFF: begin
        if (i_ac_in_regulation) begin
          st_d  = psm_pkg::PSM_WAIT;
          cnt_d = bus_mode_q ? DELAY_LD : LEAD_LD;
        end
      end
      psm_pkg::PSM_WAIT: begin
        if (!i_ac_in_regulation) begin
          st_d = psm_pkg::PSM_OFF;
        end else if (cnt_done) begin
          st_d  = psm_pkg::PSM_RAMP;
          cnt_d = RAMP_LD;
        end
      end
      psm_pkg::PSM_RAMP: begin
        if (!i_ac_in_regulation) begin
          st_d  = psm_pkg::PSM_WARN;
          cnt_d = PG_LD;
        end else if (cnt_done) begin
          st_d = psm_pkg::PSM_ON;
        end
      end
      psm_pkg::PSM_ON: begin
        if (!i_ac_in_regulation) begin
          st_d  = psm_pkg::PSM_WARN;
          cnt_d = PG_LD;
        end
      end
      psm_pkg::PSM_WARN: begin
        if (cnt_done) begin
          st_d = psm_pkg::PSM_OFF;
        end
      end
      default: begin
        st_d  = psm_pkg::PSM_OFF;
        cnt_d = '0;
      end
    endcase
    aux_d  = (st_d != psm_pkg::PSM_OFF);
    men_d  = (st_d == psm_pkg::PSM_RAMP) || (st_d == psm_pkg::PSM_ON) ||
             (st_d == psm_pkg::PSM_WARN);
    ramp_d = (st_d == psm_pkg::PSM_RAMP);
    reg_d  = (st_d == psm_pkg::PSM_ON);
    pgw_d  = (st_d == psm_pkg::PSM_WARN);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q   <= psm_pkg::PSM_OFF;
      cnt_q  <= '0;
      aux_q  <= 1'b0;
      men_q  <= 1'b0;
      ramp_q <= 1'b0;
      reg_q  <= 1'b0;
      pgw_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      aux_q  <= aux_d;
      men_q  <= men_d;
      ramp_q <= ramp_d;
      reg_q  <= reg_d;
      pgw_q  <= pgw_d;
    end
  end

  // --------------------------------------------------------------------------
  // Input LED blink
  // --------------------------------------------------------------------------
  logic [`PSM_CNT_W-1:0] blk_cnt_q, blk_cnt_d;
  logic                  led_q, led_d;

  always_comb begin
    blk_cnt_d = BLINK_LD;
    led_d     = 1'b0;
    if (i_ac_below_80v) begin
      blk_cnt_d = (blk_cnt_q == '0) ? BLINK_LD : blk_cnt_q - `PSM_CNT_W'(1);
      led_d     = (blk_cnt_q == '0) ? !led_q : led_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      blk_cnt_q <= '0;
      led_q     <= 1'b0;
    end else begin
      blk_cnt_q <= blk_cnt_d;
      led_q     <= led_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_bus_mode                = bus_mode_q;
  assign o_rs485_mode              = rs485_q;
  assign o_addr_ack                = ack_q;
  assign o_addr_read               = read_q;
  assign o_invalid_cmd             = inval_q;
  assign o_setpoint_code           = setpt_q;
  assign o_fw_vset_owner           = owner_q;
  assign o_auxiliary_supply_output = aux_q;
  assign o_main_enable             = men_q;
  assign o_main_ramping            = ramp_q;
  assign o_main_in_regulation      = reg_q;
  assign o_power_good_warning      = pgw_q;
  assign o_input_led_blink         = led_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Aux on-time for lead check
  logic [`PSM_CNT_W-1:0] aux_age_q, aux_age_d;

  always_comb begin
    aux_age_d = aux_q ? aux_age_q + `PSM_CNT_W'(1) : '0;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aux_age_q <= '0;
    end else begin
      aux_age_q <= aux_age_d;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_bus_mode;
    i_mode_pin_open |=> o_bus_mode && !o_rs485_mode;
  endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("open mode pin not bus mode");
  property p_rs485_mode;
    !i_mode_pin_open && i_mode_pin_res_ok |=> o_rs485_mode && !o_bus_mode;
  endproperty
  a_rs485_mode: assert property (p_rs485_mode) else $error("mode resistor not RS485");
  property p_unit_hit;
    o_bus_mode && i_addr_valid &&
      i_addr_byte[`PSM_PREFIX_HI:`PSM_PREFIX_LO] == `PSM_UNIT_PREFIX &&
      i_addr_byte[`PSM_SLOT_HI:`PSM_SLOT_LO] == {i_rack_select_pin, i_unit_select_pin}
      |=> o_addr_ack;
  endproperty
  a_unit_hit: assert property (p_unit_hit) else $error("own address not acked");
  property p_dir;
    o_addr_ack |-> o_addr_read == $past(i_addr_byte[`PSM_DIR_BIT]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit lost");
  property p_bcast_read;
    o_bus_mode && i_addr_valid && i_addr_byte == {`PSM_BCAST_ADDR7, 1'b1}
      |=> o_invalid_cmd && !o_addr_ack;
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast read not flagged");
  property p_nominal;
    !o_fw_vset_owner && !i_fw_vset_valid && i_vprog_open_or_high
      |=> o_setpoint_code == `PSM_NOMINAL_SETPT;
  endproperty
  a_nominal: assert property (p_nominal) else $error("nominal setpoint not used");
  property p_owner_hold;
    o_fw_vset_owner && !i_fw_vset_valid |=> $stable(o_setpoint_code) && o_fw_vset_owner;
  endproperty
  a_owner_hold: assert property (p_owner_hold) else $error("pin changed owned setpoint");
  property p_delay;
    o_bus_mode && st_q == psm_pkg::PSM_OFF && i_ac_in_regulation |=> !o_main_enable [*2];
  endproperty
  a_delay: assert property (p_delay) else $error("main started without delay");
  property p_ramp_end;
    o_main_ramping && cnt_done && i_ac_in_regulation |=> o_main_in_regulation;
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp did not end");
  property p_pg_first;
    $fell(o_main_enable) |-> $past(o_power_good_warning);
  endproperty
  a_pg_first: assert property (p_pg_first) else $error("output dropped without warning");
  property p_aux_lead;
    $rose(o_main_in_regulation) |-> o_auxiliary_supply_output && aux_age_q > LEAD_LD;
  endproperty
  a_aux_lead: assert property (p_aux_lead) else $error("aux lead time too short");
  property p_blink;
    i_ac_below_80v && blk_cnt_q == '0 |=> o_input_led_blink != $past(o_input_led_blink);
  endproperty
  a_blink: assert property (p_blink) else $error("input LED did not toggle");

  c_unit_ack: cover property (o_addr_ack && o_addr_read);
  c_in_reg:   cover property ($rose(o_main_in_regulation));
  c_warn:     cover property ($fell(o_main_enable));
  c_fw_own:   cover property ($rose(o_fw_vset_owner));

endmodule

`default_nettype wire

// File: psm_host_model.sv
`default_nettype none

module psm_host_model (
  // Clock
  input  wire logic       i_core_clk,
  // Address byte towards the supply
  output logic [7:0]      o_addr_byte,
  output logic            o_addr_valid,
  // Executed firmware voltage command
  output logic            o_fw_vset_valid,
  output logic [7:0]      o_fw_vset_code
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_addr_byte     = 8'h5A;
    o_addr_valid    = 1'b0;
    o_fw_vset_valid = 1'b0;
    o_fw_vset_code  = 8'hA5;
  end

  // ---------------------------------------------------------------------------
  // Address byte, direction in bit 0; broadcast reads only when asked for
  // ---------------------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    @(posedge i_core_clk);
    o_addr_byte  <= b;
    o_addr_valid <= 1'b1;
    @(posedge i_core_clk);
    o_addr_byte  <= ~b;
    o_addr_valid <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Voltage command, code lines scrambled once released
  // ---------------------------------------------------------------------------
  task automatic fw(input logic [7:0] c);
    @(posedge i_core_clk);
    o_fw_vset_code  <= c;
    o_fw_vset_valid <= 1'b1;
    @(posedge i_core_clk);
    o_fw_vset_code  <= ~c;
    o_fw_vset_valid <= 1'b0;
  endtask
endmodule

`default_nettype wire

// File: psu_mgmt_address_and_control_tb_top.sv
`default_nettype none

module psu_mgmt_address_and_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int D = 20;
  localparam int R = 10;
  localparam int P = 5;
  localparam int L = 8;
  localparam int B = 4;

  logic       clk, rst, m_open, m_res, vp_open, ac_ok, ac_low;
  logic [1:0] unit, rack;
  logic [7:0] vp_code, a_byte, fw_code, setpt;
  logic       a_valid, fw_valid, bus_mode, rs_mode, ack, rd, inv, owner;
  logic       aux, main_en, ramp, reg_ok, warn, led;
  int         errors, tests_run, seed;

  psm_host_model host (
    .i_core_clk      (clk),
    .o_addr_byte     (a_byte),
    .o_addr_valid    (a_valid),
    .o_fw_vset_valid (fw_valid),
    .o_fw_vset_code  (fw_code)
  );

  psm_top #(.DELAY_CYC(D), .RAMP_CYC(R), .PG_CYC(P), .LEAD_CYC(L), .BLINK_CYC(B)) dut (
    .i_core_clk (clk), .i_reset (rst),
    .i_mode_pin_open (m_open), .i_mode_pin_res_ok (m_res),
    .i_unit_select_pin (unit), .i_rack_select_pin (rack),
    .i_addr_byte (a_byte), .i_addr_valid (a_valid),
    .i_vprog_open_or_high (vp_open), .i_vprog_code (vp_code),
    .i_fw_vset_valid (fw_valid), .i_fw_vset_code (fw_code),
    .i_ac_in_regulation (ac_ok), .i_ac_below_80v (ac_low),
    .o_bus_mode (bus_mode), .o_rs485_mode (rs_mode),
    .o_addr_ack (ack), .o_addr_read (rd), .o_invalid_cmd (inv),
    .o_setpoint_code (setpt), .o_fw_vset_owner (owner),
    .o_auxiliary_supply_output (aux), .o_main_enable (main_en),
    .o_main_ramping (ramp), .o_main_in_regulation (reg_ok),
    .o_power_good_warning (warn), .o_input_led_blink (led)
  );

  // ---------------------------------------------------------------------------
  // Checking and verdict
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic exp_ack(input logic [7:0] b, input logic [3:0] s);
    return (b[7:5] == 3'h4 && b[4:1] == s) || b == 8'h00 || b == 8'h19;
  endfunction

  // ---------------------------------------------------------------------------
  // Start-up, ramp and loss of input; wait is the start delay of the mode
  // ---------------------------------------------------------------------------
  task automatic seq_run(input int wt);
    int t_aux, t_main, t_reg, t_off, n;
    t_aux = -1;
    t_main = -1;
    t_reg = -1;
    t_off = -1;
    @(posedge clk);
    ac_ok <= 1'b1;
    for (n = 0; n < 200 && t_reg < 0; n++) begin
      @(negedge clk);
      if (aux && t_aux < 0) t_aux = n;
      if (main_en && t_main < 0) t_main = n;
      if (main_en && !reg_ok) check("ramping", ramp, 16'h1);
      if (reg_ok && t_reg < 0) t_reg = n;
    end
    check("aux_time", t_aux[15:0], 16'h1);
    check("main_time", t_main[15:0], 16'(1 + wt));
    check("reg_time", t_reg[15:0], 16'(1 + wt + R));
    check("aux_lead", (t_reg - t_aux) >= L, 16'h1);
    @(posedge clk);
    ac_ok <= 1'b0;
    for (n = 0; n < 50 && t_off < 0; n++) begin
      @(negedge clk);
      if (n == 1) check("warn_reg", {warn, reg_ok}, 16'h2);
      if (!main_en && n > 0) t_off = n;
    end
    check("off_time", t_off[15:0], 16'(1 + P));
    check("off_state", {warn, aux, ramp}, 16'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    logic [3:0] s;
    logic [7:0] b, c, f;
    seed = 32'ha8bf115e;
    errors = 0;
    tests_run = 0;
    {rst, m_open} = 2'b11;
    {m_res, vp_open, ac_ok, ac_low} = 4'b0100;
    {unit, rack} = 4'h0;
    vp_code = 8'h30;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset_out", {bus_mode, setpt}, 16'h136);
    check("reset_flags", {rs_mode, ack, rd, inv, owner, aux, main_en,
                          ramp, reg_ok, warn, led}, 16'h0);
    // Mode pin: open, resistor, neither; own address refused in RS485
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      m_open <= (i == 0);
      m_res <= (i == 1);
      @(posedge clk);
      @(negedge clk);
      check("mode", {bus_mode, rs_mode}, (i == 1) ? 16'h1 : 16'h2);
      host.send({3'h4, rack, unit, 1'b0});
      @(negedge clk);
      check("mode_ack", ack, i != 1);
    end
    // Address matching across slots and special addresses
    for (int i = 0; i < 48; i++) begin
      s = 4'($random(seed));
      b = 8'($random(seed));
      @(posedge clk);
      {rack, unit} <= s;
      case (i % 6)
        0: b = {3'h4, s, b[0]};
        1: b = 8'h00;
        2: b = 8'h01;
        3: b = 8'h19;
        4: b = {3'h4, ~s, b[0]};
        default: ;
      endcase
      host.send(b);
      @(negedge clk);
      check("addr_ack", ack, exp_ack(b, s));
      check("addr_inv", inv, b == 8'h01);
      check("addr_dir", rd, b[0]);
    end
    // Setpoint from pin until a firmware command, then pin ignored
    f = 8'h00;
    for (int i = 0; i < 10; i++) begin
      c = 8'($random(seed));
      @(posedge clk);
      vp_code <= c;
      vp_open <= i[0];
      if (i == 5) begin
        f = 8'($random(seed));
        host.fw(f);
      end else begin
        @(posedge clk);
      end
      @(negedge clk);
      check("setpoint", setpt, (i >= 5) ? f : (i[0] ? 8'h36 : c));
      check("owner", owner, i >= 5);
    end
    // Sequencing in bus mode, then in RS485 mode
    @(posedge clk);
    {m_open, m_res} <= 2'b10;
    seq_run(D);
    @(posedge clk);
    {m_open, m_res} <= 2'b01;
    seq_run(L);
    // Input LED blinking while input is low
    @(posedge clk);
    ac_low <= 1'b1;
    for (int n = 0; n < 3 * B + 2; n++) begin
      @(negedge clk);
      check("led", led, ((n / B) % 2) == 1);
    end
    @(posedge clk);
    ac_low <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("led_off", led, 16'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire
